// ==== include/adcp_pkg.sv ====
/*
 * adcp_pkg: constants and types for the adc parallel host port.
 * assumes one 50 MHz system clock and a converter core beside the port.
 */
package adcp_pkg;

    // pin-side data bus
    localparam int DATA_W      = 12;
    localparam int ADDR_LO     = 10;
    localparam int CTRL_W      = 10;
    localparam int FIFO_DEPTH  = 16;
    localparam int FIFO_AW     = 4;

    // control register 0 and 1 (pin-side writes)
    localparam logic [1:0] CR0_ADDR     = 2'h0;
    localparam logic [1:0] CR1_ADDR     = 2'h1;
    localparam int         CR0_SINGLE   = 1;
    localparam int         CR1_DAV_PLS  = 0;
    localparam int         CR1_DAV_HI   = 1;
    localparam int         CR1_TRIG_LO  = 2;
    localparam int         CR1_FIFO_RST = 4;
    localparam int         CR1_SEP_STB  = 5;
    localparam logic [CTRL_W-1:0] CR0_RST = 10'h000;
    localparam logic [CTRL_W-1:0] CR1_RST = 10'h000;

    // pipeline latency before first data-available after fifo reset
    localparam logic [4:0] PIPE_LAT = 5'h07;

    // avalon word addresses
    localparam logic [2:0] REG_STATUS = 3'h0;
    localparam logic [2:0] REG_MASK   = 3'h1;
    localparam logic [2:0] REG_CTRL0  = 3'h2;
    localparam logic [2:0] REG_CTRL1  = 3'h3;
    localparam logic [2:0] REG_LEVEL  = 3'h4;

    // status / mask bit positions
    localparam int EV_START = 0;
    localparam int EV_OVFL  = 1;
    localparam int EV_CFGWR = 2;
    localparam int EV_DAV   = 3;
    localparam int EV_W     = 4;

    typedef struct packed {
        logic              valid;
        logic [DATA_W-1:0] data;
    } adcp_sample_s;

endpackage : adcp_pkg

// ==== verilog/adcp_host_port.sv ====
/*
 * adcp_host_port: processor-side parallel port of a four-input sampling adc.
 * holds the pin decode, the control registers, the 16-word sample fifo,
 * the data-available output and an avalon-mm status/interrupt slave.
 * assumes pins already synchronous to clk_sys; converter core pushes
 * samples through smp_in and consumes the start/tick pulses.
 */
// Operation
// [RQ1] select needs low select and high select
// [RQ2] host supplies conversion clock in continuous mode
// [RQ3] single mode: falling start edge holds all
// [RQ4] data-available: fifo level, polarity, level or pulse
// [RQ5] data bits 11:10 address control register
// [RQ6] twelve-bit bidirectional bus, bit 0 lsb
// [RQ7] write pin is read/write or write strobe
// [RQ8] read strobe only used with separate strobes
// [RQ9] host first access must be configuration write
// [RQ10] control 0 bit 1 picks single mode
// [RQ11] continuous: first data-available after seven plus level
// [RQ12] drive bus only during selected read
module adcp_host_port
    import adcp_pkg::*;
(
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    // host pins
    input  wire logic              select_active_low,
    input  wire logic              select_active_high,
    input  wire logic              wr_pin,
    input  wire logic              rd_n,
    input  wire logic [DATA_W-1:0] data_in,
    output logic      [DATA_W-1:0] data_out,
    output logic                   data_oe,
    input  wire logic              conversion_clock_in,
    output logic                   sample_ready_flag,
    // converter core side
    input  wire adcp_sample_s      smp_in,
    output logic                   hold_start,
    output logic                   conv_tick,
    output logic                   single_mode,
    // avalon-mm slave
    input  wire logic [2:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    output logic                   irq
);

    function automatic logic [4:0] trig_level(input logic [1:0] sel);
        unique case (sel)
            2'h0:    trig_level = 5'h01;
            2'h1:    trig_level = 5'h04;
            2'h2:    trig_level = 5'h08;
            default: trig_level = 5'h0e;
        endcase
    endfunction : trig_level

    // pin decode
    logic                selected;
    logic                wr_act;
    logic                rd_act;
    logic                wr_prev_ff;
    logic                rd_prev_ff;
    logic                conv_prev_ff;
    logic [CTRL_W-1:0]   ctrl0_ff;
    logic [CTRL_W-1:0]   ctrl1_ff;
    logic [CTRL_W-1:0]   nxt_ctrl0;
    logic [CTRL_W-1:0]   nxt_ctrl1;
    logic                wr_start;
    logic                rd_start;
    logic                fifo_rst;
    logic                conv_fall;
    logic                conv_rise;

    assign selected  = !select_active_low && select_active_high; // [RQ1]
    always_comb
    begin
        if (ctrl1_ff[CR1_SEP_STB])
        begin
            wr_act = selected && !wr_pin;                        // [RQ7]
            rd_act = selected && !rd_n;                          // [RQ8]
        end
        else
        begin
            wr_act = selected && !wr_pin;                        // [RQ7]
            rd_act = selected && wr_pin;
        end
    end
    assign wr_start  = wr_act && !wr_prev_ff;
    assign rd_start  = rd_act && !rd_prev_ff;
    assign conv_fall = conv_prev_ff && !conversion_clock_in;
    assign conv_rise = !conv_prev_ff && conversion_clock_in;
    assign single_mode = ctrl0_ff[CR0_SINGLE];                   // [RQ10]
    assign fifo_rst  = wr_start && (data_in[DATA_W-1:ADDR_LO] == CR1_ADDR)
                       && data_in[CR1_FIFO_RST];

    // control registers; fifo reset bit is a command, not stored
    always_comb
    begin
        nxt_ctrl0 = ctrl0_ff;
        nxt_ctrl1 = ctrl1_ff;
        if (wr_start)
        begin
            unique case (data_in[DATA_W-1:ADDR_LO])              // [RQ5]
                CR0_ADDR: nxt_ctrl0 = data_in[CTRL_W-1:0];
                CR1_ADDR:
                begin
                    nxt_ctrl1 = data_in[CTRL_W-1:0];
                    nxt_ctrl1[CR1_FIFO_RST] = 1'b0;
                end
                default:  nxt_ctrl0 = ctrl0_ff;
            endcase
        end
    end

    // converter pulses: start edge in single mode, tick in continuous
    assign hold_start = single_mode && conv_fall;                // [RQ3]
    assign conv_tick  = !single_mode && conv_rise;               // [RQ2]

    // sample fifo
    logic [DATA_W-1:0]   mem [FIFO_DEPTH];
    logic [FIFO_AW-1:0]  wptr_ff;
    logic [FIFO_AW-1:0]  rptr_ff;
    logic [FIFO_AW:0]    count_ff;
    logic [FIFO_AW-1:0]  nxt_wptr;
    logic [FIFO_AW-1:0]  nxt_rptr;
    logic [FIFO_AW:0]    nxt_count;
    logic                push;
    logic                pop;
    logic                ovfl;
    logic [DATA_W-1:0]   dout_ff;
    logic [DATA_W-1:0]   nxt_dout;

    assign push = smp_in.valid && (count_ff != FIFO_DEPTH[FIFO_AW:0]);
    assign ovfl = smp_in.valid && (count_ff == FIFO_DEPTH[FIFO_AW:0]);
    assign pop  = rd_start && (count_ff != '0);

    always_comb
    begin
        nxt_wptr  = wptr_ff + FIFO_AW'(push);
        nxt_rptr  = rptr_ff + FIFO_AW'(pop);
        nxt_count = count_ff + (FIFO_AW+1)'(push) - (FIFO_AW+1)'(pop);
        nxt_dout  = pop ? mem[rptr_ff] : dout_ff;
        if (fifo_rst)
        begin
            nxt_wptr  = '0;
            nxt_rptr  = '0;
            nxt_count = '0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (push)
            mem[wptr_ff] <= smp_in.data;
    end

    assign data_out = dout_ff;                                   // [RQ6]
    assign data_oe  = rd_act;                                    // [RQ12]

    // data-available with post-reset holdoff
    logic [4:0]          hold_cnt_ff;
    logic [4:0]          nxt_hold_cnt;
    logic                dav_lvl_ff;
    logic                nxt_dav_lvl;
    logic                dav_level;
    logic                dav_assert;
    logic [4:0]          trigger_level;

    assign trigger_level = trig_level(ctrl1_ff[CR1_TRIG_LO +: 2]);
    assign dav_level = (count_ff >= trigger_level) && (hold_cnt_ff == '0);

    always_comb
    begin
        nxt_hold_cnt = hold_cnt_ff;
        // level written with the reset command, not the old one
        if (fifo_rst && !single_mode)                            // [RQ11]
            nxt_hold_cnt = PIPE_LAT + trig_level(data_in[3:2]);
        else if (conv_tick && hold_cnt_ff != '0)
            nxt_hold_cnt = hold_cnt_ff - 5'h01;
        nxt_dav_lvl = dav_level;
    end

    assign dav_assert = ctrl1_ff[CR1_DAV_PLS] ? (dav_level && !dav_lvl_ff)
                                               : dav_level;     // [RQ4]
    assign sample_ready_flag = ctrl1_ff[CR1_DAV_HI] ? dav_assert
                                                    : !dav_assert; // [RQ4]

    // avalon slave with sticky status
    logic [EV_W-1:0]     status_ff;
    logic [EV_W-1:0]     mask_ff;
    logic [EV_W-1:0]     nxt_status;
    logic [EV_W-1:0]     nxt_mask;
    logic [EV_W-1:0]     events;
    logic                ack_ff;
    logic                nxt_ack;
    logic [31:0]         rdata_ff;
    logic [31:0]         nxt_rdata;

    assign events = {dav_level && !dav_lvl_ff, wr_start, ovfl, hold_start};

    always_comb
    begin
        nxt_ack    = (avs_read || avs_write) && !ack_ff;
        nxt_mask   = mask_ff;
        nxt_status = status_ff;
        nxt_rdata  = rdata_ff;
        if (avs_write && ack_ff && avs_address == REG_STATUS)
            nxt_status = status_ff & ~avs_writedata[EV_W-1:0];
        if (avs_write && ack_ff && avs_address == REG_MASK)
            nxt_mask = avs_writedata[EV_W-1:0];
        // a new event wins over a clear in the same cycle
        nxt_status = nxt_status | events;
        if (avs_read && !ack_ff)
        begin
            unique case (avs_address)
                REG_STATUS: nxt_rdata = {28'h0000000, status_ff};
                REG_MASK:   nxt_rdata = {28'h0000000, mask_ff};
                REG_CTRL0:  nxt_rdata = {22'h000000, ctrl0_ff};
                REG_CTRL1:  nxt_rdata = {22'h000000, ctrl1_ff};
                REG_LEVEL:  nxt_rdata = {27'h0000000, count_ff};
                default:    nxt_rdata = 32'h00000000;
            endcase
        end
    end

    assign avs_waitrequest = (avs_read || avs_write) && !ack_ff;
    assign avs_readdata    = rdata_ff;
    assign irq             = |(status_ff & mask_ff);

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_prev_ff   <= 1'b0;
            rd_prev_ff   <= 1'b0;
            conv_prev_ff <= 1'b0;
            ctrl0_ff     <= CR0_RST;
            ctrl1_ff     <= CR1_RST;
            wptr_ff      <= '0;
            rptr_ff      <= '0;
            count_ff     <= '0;
            dout_ff      <= '0;
            hold_cnt_ff  <= '0;
            dav_lvl_ff   <= 1'b0;
            status_ff    <= '0;
            mask_ff      <= '0;
            ack_ff       <= 1'b0;
            rdata_ff     <= '0;
        end
        else
        begin
            wr_prev_ff   <= wr_act;
            rd_prev_ff   <= rd_act;
            conv_prev_ff <= conversion_clock_in;
            ctrl0_ff     <= nxt_ctrl0;
            ctrl1_ff     <= nxt_ctrl1;
            wptr_ff      <= nxt_wptr;
            rptr_ff      <= nxt_rptr;
            count_ff     <= nxt_count;
            dout_ff      <= nxt_dout;
            hold_cnt_ff  <= nxt_hold_cnt;
            dav_lvl_ff   <= nxt_dav_lvl;
            status_ff    <= nxt_status;
            mask_ff      <= nxt_mask;
            ack_ff       <= nxt_ack;
            rdata_ff     <= nxt_rdata;
        end
    end

    property p_sel_gate;
        @(posedge clk_sys) disable iff (!rst_n)
        (select_active_low || !select_active_high) |-> !data_oe;
    endproperty
    a_sel_gate: assert property (p_sel_gate)                     // [RQ1]
        else $error("bus driven while not selected");

    property p_hold_edge;
        @(posedge clk_sys) disable iff (!rst_n)
        (single_mode && $past(conversion_clock_in) && !conversion_clock_in)
        |-> hold_start && !conv_tick;
    endproperty
    a_hold_edge: assert property (p_hold_edge)                   // [RQ3]
        else $error("falling start edge gave no hold");

    property p_hold_sts;
        @(posedge clk_sys) disable iff (!rst_n)
        hold_start |=> status_ff[EV_START];
    endproperty
    a_hold_sts: assert property (p_hold_sts)                     // [RQ3]
        else $error("start event not recorded");

    property p_dav_pol;
        @(posedge clk_sys) disable iff (!rst_n)
        (!ctrl1_ff[CR1_DAV_PLS] && count_ff == 5'h00)
        |-> sample_ready_flag == !ctrl1_ff[CR1_DAV_HI];
    endproperty
    a_dav_pol: assert property (p_dav_pol)                       // [RQ4]
        else $error("data-available active with empty fifo");

    property p_cr_addr;
        @(posedge clk_sys) disable iff (!rst_n)
        (wr_start && data_in[11:10] == 2'h0)
        |=> ctrl0_ff == $past(data_in[CTRL_W-1:0]);
    endproperty
    a_cr_addr: assert property (p_cr_addr)                       // [RQ5]
        else $error("control 0 write not stored");

    property p_rd_drive;
        @(posedge clk_sys) disable iff (!rst_n)
        (ctrl1_ff[CR1_SEP_STB] && rd_n) |-> !data_oe;
    endproperty
    a_rd_drive: assert property (p_rd_drive)                     // [RQ8]
        else $error("bus driven without read strobe");

    property p_mode;
        @(posedge clk_sys) disable iff (!rst_n)
        conv_tick |-> !ctrl0_ff[1] && !hold_start;
    endproperty
    a_mode: assert property (p_mode)                             // [RQ10]
        else $error("tick seen in single mode");

    property p_holdoff;
        @(posedge clk_sys) disable iff (!rst_n)
        (fifo_rst && !single_mode)
        |=> hold_cnt_ff == PIPE_LAT + trigger_level && !dav_level;
    endproperty
    a_holdoff: assert property (p_holdoff)                       // [RQ11]
        else $error("holdoff not loaded after fifo reset");

    property p_wait;
        @(posedge clk_sys) disable iff (!rst_n)
        (avs_read && avs_waitrequest) |=> !avs_waitrequest;
    endproperty
    a_wait: assert property (p_wait)
        else $error("avalon read not answered in one cycle");

endmodule : adcp_host_port

// ==== sim/adcp_host_model.sv ====
/*
 * adcp_host_model: processor on the parallel pins of the adc port.
 * assumes the bench resolves the shared data bus from data_oe alone.
 */
module adcp_host_model
    import adcp_pkg::*;
(
    // clock and resolved bus
    input  wire logic              clk_sys,
    input  wire logic [DATA_W-1:0] bus,
    input  wire logic              data_oe,
    // pins driven by the host
    output logic                   select_active_low,
    output logic                   select_active_high,
    output logic                   wr_pin,
    output logic                   rd_n,
    output logic                   conversion_clock_in,
    output logic      [DATA_W-1:0] host_data
);
    timeunit 1ns;
    timeprecision 1ps;

    logic sep_stb;

    initial
    begin
        select_active_low   = 1'b1;
        select_active_high  = 1'b0;
        wr_pin              = 1'b1;
        rd_n                = 1'b1;
        conversion_clock_in = 1'b0;
        host_data           = '0;
        sep_stb             = 1'b0;
    end

    // released lines show the inverse word: no pull-up on the bus
    task automatic write_word(input logic [1:0] addr,
                              input logic [CTRL_W-1:0] val);
        @(posedge clk_sys);
        select_active_low  <= 1'b0;
        select_active_high <= 1'b1;
        wr_pin             <= 1'b0;
        host_data          <= {addr, val};
        @(posedge clk_sys);
        select_active_low  <= 1'b1;
        select_active_high <= 1'b0;
        wr_pin             <= 1'b1;
        host_data          <= ~{addr, val};
        if (addr == CR1_ADDR)
            sep_stb = val[CR1_SEP_STB];
    endtask : write_word

    // r/w mode reads with wr_pin high; strobe mode uses rd_n
    task automatic read_word(input logic sel, output logic [DATA_W-1:0] q,
                             output logic oe);
        @(posedge clk_sys);
        select_active_low  <= 1'b0;
        select_active_high <= sel;
        if (sep_stb)
            rd_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        q = bus;
        oe = data_oe;
        select_active_low  <= 1'b1;
        select_active_high <= 1'b0;
        rd_n               <= 1'b1;
    endtask : read_word

    // clock stands low between bursts
    task automatic conv_cycles(input int n);
        repeat (n)
        begin
            @(posedge clk_sys);
            conversion_clock_in <= 1'b1;
            repeat (2) @(posedge clk_sys);
            conversion_clock_in <= 1'b0;
            repeat (2) @(posedge clk_sys);
        end
    endtask : conv_cycles

endmodule : adcp_host_model

// ==== sim/adcp_host_port_tb_top.sv ====
/*
 * adcp_host_port_tb_top: self-checking bench for the adc host port.
 * assumes the host model's first pin access is a configuration write.
 */
module adcp_host_port_tb_top;
    import adcp_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_sys, rst_n, sal, sah, wr_pin, rd_n, conv, data_oe, flag;
    logic hold_start, conv_tick, single_mode, avs_read, avs_write;
    logic avs_waitrequest, irq;
    logic [DATA_W-1:0] data_out, host_data, bus, q;
    logic [2:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    adcp_sample_s smp_in;
    logic oe;
    int err_count, check_count, cycles, hold_cnt, tick_cnt, pulse_cnt;

    assign bus = data_oe ? data_out : host_data;

    adcp_host_port dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .select_active_low(sal), .select_active_high(sah),
        .wr_pin(wr_pin), .rd_n(rd_n), .data_in(bus), .data_out(data_out),
        .data_oe(data_oe), .conversion_clock_in(conv),
        .sample_ready_flag(flag), .smp_in(smp_in),
        .hold_start(hold_start), .conv_tick(conv_tick),
        .single_mode(single_mode), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq));

    adcp_host_model host (.clk_sys(clk_sys), .bus(bus), .data_oe(data_oe),
        .select_active_low(sal), .select_active_high(sah),
        .wr_pin(wr_pin), .rd_n(rd_n), .conversion_clock_in(conv),
        .host_data(host_data));

    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
    begin
        cycles   <= cycles + 1;
        hold_cnt <= hold_cnt + int'(hold_start === 1'b1);
        tick_cnt <= tick_cnt + int'(conv_tick === 1'b1);
        pulse_cnt <= pulse_cnt + int'(flag === 1'b1);
        if (cycles == 20000)
        begin
            err_count = err_count + 1;
            complete_run();
        end
    end

    task automatic chk_val(input string name, input logic [31:0] exp,
                           input logic [31:0] got);
        check_count = check_count + 1;
        if (got !== exp)
        begin
            err_count = err_count + 1;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_val

    task automatic chk_bit(input string name, input logic exp, input logic got);
        chk_val(name, {31'h0, exp}, {31'h0, got});
    endtask : chk_bit

    task automatic av_xfer(input logic wr, input logic [2:0] a,
                           input logic [31:0] d);
        @(posedge clk_sys);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= ~wr;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : av_xfer

    task automatic push(input logic [DATA_W-1:0] d);
        @(posedge clk_sys);
        smp_in <= '{valid: 1'b1, data: d};
        @(posedge clk_sys);
        smp_in <= '0;
        @(posedge clk_sys);
    endtask : push

    task automatic t_regs();
        av_xfer(1'b0, REG_STATUS, 32'h0);
        chk_val("status", 32'h0, rd);
        av_xfer(1'b1, REG_MASK, 32'h0000000f);
        av_xfer(1'b0, REG_MASK, 32'h0);
        chk_val("mask", 32'h0000000f, rd);
        av_xfer(1'b0, 3'h5, 32'h0);
        chk_val("unmapped", 32'h0, rd);
        av_xfer(1'b1, REG_MASK, 32'h00000001);
        $display("test regs done");
    endtask : t_regs

    task automatic t_config();
        host.write_word(CR1_ADDR, 10'h000);
        av_xfer(1'b0, REG_STATUS, 32'h0);
        chk_val("cfg event", 32'h00000004, rd);
        av_xfer(1'b1, REG_STATUS, 32'h00000004);
        host.write_word(CR0_ADDR, 10'h002);
        av_xfer(1'b0, REG_CTRL0, 32'h0);
        chk_val("ctrl0", 32'h00000002, rd);
        chk_bit("single_mode", 1'b1, single_mode);
        $display("test config done");
    endtask : t_config

    task automatic t_single();
        av_xfer(1'b1, REG_STATUS, 32'h0000000f);
        host.conv_cycles(1);
        repeat (3) @(posedge clk_sys);
        chk_val("hold pulses", 32'h1, hold_cnt);
        chk_val("ticks", 32'h0, tick_cnt);
        chk_bit("irq set", 1'b1, irq);
        av_xfer(1'b1, REG_STATUS, 32'h00000001);
        @(posedge clk_sys);
        chk_bit("irq clear", 1'b0, irq);
        $display("test single done");
    endtask : t_single

    task automatic t_fifo_rw();
        push(12'h5a3);
        push(12'ha5c);
        chk_bit("flag low", 1'b0, flag);
        av_xfer(1'b0, REG_LEVEL, 32'h0);
        chk_val("level", 32'h2, rd);
        host.read_word(1'b0, q, oe);
        chk_bit("oe unselected", 1'b0, oe);
        host.read_word(1'b1, q, oe);
        chk_val("word 0", 32'h5a3, q);
        chk_bit("oe read", 1'b1, oe);
        host.read_word(1'b1, q, oe);
        chk_val("word 1", 32'ha5c, q);
        @(posedge clk_sys);
        chk_bit("flag empty", 1'b1, flag);
        chk_bit("oe idle", 1'b0, data_oe);
        $display("test fifo r/w done");
    endtask : t_fifo_rw

    task automatic t_strobes();
        host.write_word(CR1_ADDR, 10'h022);
        av_xfer(1'b0, REG_CTRL1, 32'h0);
        chk_val("ctrl1", 32'h00000022, rd);
        push(12'h801);
        chk_bit("flag high", 1'b1, flag);
        host.read_word(1'b1, q, oe);
        chk_val("strobe word", 32'h801, q);
        $display("test strobes done");
    endtask : t_strobes

    task automatic t_holdoff();
        host.write_word(CR0_ADDR, 10'h000);
        host.write_word(CR1_ADDR, 10'h030);
        push(12'h123);
        host.conv_cycles(7);
        chk_val("ticks", 32'h7, tick_cnt);
        chk_bit("flag held", 1'b1, flag);
        host.conv_cycles(1);
        @(posedge clk_sys);
        chk_bit("flag after", 1'b0, flag);
        $display("test holdoff done");
    endtask : t_holdoff

    // pulse output, trigger level 4, then fill to overflow
    task automatic t_pulse();
        int base;
        host.write_word(CR1_ADDR, 10'h027);
        base = pulse_cnt;
        repeat (2) push(12'h0aa);
        @(posedge clk_sys);
        chk_val("below level", base, pulse_cnt);
        push(12'h0bb);
        @(posedge clk_sys);
        chk_val("one pulse", base + 1, pulse_cnt);
        chk_bit("pulse ends", 1'b0, flag);
        repeat (12) push(12'h0cc);
        av_xfer(1'b1, REG_STATUS, 32'h0000000f);
        push(12'h0dd);
        av_xfer(1'b0, REG_STATUS, 32'h0);
        chk_val("overflow", 32'h00000002, rd);
        av_xfer(1'b0, REG_LEVEL, 32'h0);
        chk_val("full level", 32'h00000010, rd);
        chk_val("pulse once", base + 1, pulse_cnt);
        $display("test pulse done");
    endtask : t_pulse

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run

    initial
    begin
        rst_n = 1'b0;
        smp_in = '0;
        avs_address = 3'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        err_count = 0;
        check_count = 0;
        cycles = 0;
        hold_cnt = 0;
        tick_cnt = 0;
        pulse_cnt = 0;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_regs();
        t_config();
        t_single();
        t_fifo_rw();
        t_strobes();
        t_holdoff();
        t_pulse();
        complete_run();
    end

endmodule : adcp_host_port_tb_top
